// >>> common/hvrcs_cfg.svh
`ifndef HVRCS_CFG_SVH
`define HVRCS_CFG_SVH
// system clock rate and serial line rate
`define HVRCS_CLK_HZ 20000000
`define HVRCS_BAUD 9600
`define HVRCS_BIT_CYC (`HVRCS_CLK_HZ / `HVRCS_BAUD)
`define HVRCS_DATA_BITS 8
// command framing characters
`define HVRCS_CHR_CR 8'h0D
`define HVRCS_CHR_LF 8'h0A
// limit margin of 0.02 of nominal, taken as nominal / 50
`define HVRCS_MARGIN_DIV 50
// bus address range and default
`define HVRCS_GPIB_ADDR_RST 5'h11
`define HVRCS_GPIB_ADDR_MIN 5'h01
`define HVRCS_GPIB_ADDR_MAX 5'h1E
// fixed tcp command port, 10001
`define HVRCS_TCP_PORT 16'h2711
// four-character commands decoded in hardware
`define HVRCS_CMD_CLEAR 32'h2A434C53
`define HVRCS_CMD_EMCY 32'h454D4359
`endif

// >>> common/hvrcs_pkg.sv
package hvrcs_pkg;
    // interface selection setting
    typedef enum logic [1:0] {
        HVRCS_IF_SERIAL,
        HVRCS_IF_GPIB,
        HVRCS_IF_ETH,
        HVRCS_IF_OTHER
    } hvrcs_iface_t;
    // remote/local control state
    typedef enum logic {
        HVRCS_LOCAL,
        HVRCS_REMOTE
    } hvrcs_ctrl_t;
    // serial frame state
    typedef enum logic [1:0] {
        HVRCS_U_IDLE,
        HVRCS_U_START,
        HVRCS_U_DATA,
        HVRCS_U_STOP
    } hvrcs_uart_st_t;
endpackage

// >>> logic/hvrcs_uart.sv
`timescale 1ns/1ps
`include "hvrcs_cfg.svh"
module hvrcs_uart #(
    parameter int BIT_CYC = `HVRCS_BIT_CYC
) (
    // clock and synchronised reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial pins
    input wire logic rxd,
    output logic txd,
    // received characters
    output logic rx_valid,
    output logic [7:0] rx_data,
    // characters to send
    input wire logic tx_start,
    input wire logic [7:0] tx_data,
    output logic tx_busy
);
    import hvrcs_pkg::*;
    localparam int CW = $clog2(BIT_CYC + 1);
    localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
    localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);
    logic rx_meta_reg, rx_sync_reg;
    hvrcs_uart_st_t rs_reg, rs_next, ts_reg, ts_next;
    logic [CW-1:0] rc_reg, rc_next, tc_reg, tc_next;
    logic [2:0] rb_reg, rb_next, tb_reg, tb_next;
    logic [7:0] rsh_reg, rsh_next, tsh_reg, tsh_next;
    logic rv_reg, rv_next, txd_reg, txd_next;

    // pin passes two flops before the receiver looks at it
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end
        else
        begin
            rx_meta_reg <= rxd;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // 8 data bits, no parity, one stop bit at fixed rate
    always_comb
    begin
        rs_next = rs_reg;
        rc_next = rc_reg;
        rb_next = rb_reg;
        rsh_next = rsh_reg;
        rv_next = 1'b0;
        ts_next = ts_reg;
        tc_next = tc_reg;
        tb_next = tb_reg;
        tsh_next = tsh_reg;
        txd_next = txd_reg;
        // receiver samples at mid-bit
        case (rs_reg)
            HVRCS_U_IDLE:
                if (!rx_sync_reg)
                begin
                    rs_next = HVRCS_U_START;
                    rc_next = HALF;
                end
            HVRCS_U_START:
                if (rc_reg != 0)
                    rc_next = rc_reg - 1'b1;
                else if (rx_sync_reg)
                    rs_next = HVRCS_U_IDLE; // glitch, not a start bit
                else
                begin
                    rs_next = HVRCS_U_DATA;
                    rc_next = FULL;
                    rb_next = 3'h0;
                end
            HVRCS_U_DATA:
                if (rc_reg != 0)
                    rc_next = rc_reg - 1'b1;
                else
                begin
                    rsh_next = {rx_sync_reg, rsh_reg[7:1]};
                    rc_next = FULL;
                    rb_next = rb_reg + 1'b1;
                    if (rb_reg == 3'h7)
                        rs_next = HVRCS_U_STOP;
                end
            HVRCS_U_STOP:
                if (rc_reg != 0)
                    rc_next = rc_reg - 1'b1;
                else
                begin
                    rs_next = HVRCS_U_IDLE;
                    rv_next = rx_sync_reg; // framing error drops the character
                end
            default:
                rs_next = HVRCS_U_IDLE;
        endcase
        // transmitter, start then lsb first then stop
        case (ts_reg)
            HVRCS_U_IDLE:
                if (tx_start)
                begin
                    ts_next = HVRCS_U_START;
                    tc_next = FULL;
                    tsh_next = tx_data;
                    txd_next = 1'b0;
                end
            HVRCS_U_START, HVRCS_U_DATA:
                if (tc_reg != 0)
                    tc_next = tc_reg - 1'b1;
                else
                begin
                    tc_next = FULL;
                    txd_next = tsh_reg[0];
                    tsh_next = {1'b1, tsh_reg[7:1]};
                    tb_next = (ts_reg == HVRCS_U_START) ? 3'h0 : tb_reg + 1'b1;
                    if (ts_reg == HVRCS_U_START)
                        ts_next = HVRCS_U_DATA;
                    else if (tb_reg == 3'h7)
                    begin
                        ts_next = HVRCS_U_STOP;
                        txd_next = 1'b1;
                    end
                end
            HVRCS_U_STOP:
                if (tc_reg != 0)
                    tc_next = tc_reg - 1'b1;
                else
                    ts_next = HVRCS_U_IDLE;
            default:
                ts_next = HVRCS_U_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rs_reg <= HVRCS_U_IDLE;
            rc_reg <= '0;
            rb_reg <= 3'h0;
            rsh_reg <= 8'h00;
            rv_reg <= 1'b0;
            ts_reg <= HVRCS_U_IDLE;
            tc_reg <= '0;
            tb_reg <= 3'h0;
            tsh_reg <= 8'h00;
            txd_reg <= 1'b1;
        end
        else
        begin
            rs_reg <= rs_next;
            rc_reg <= rc_next;
            rb_reg <= rb_next;
            rsh_reg <= rsh_next;
            rv_reg <= rv_next;
            ts_reg <= ts_next;
            tc_reg <= tc_next;
            tb_reg <= tb_next;
            tsh_reg <= tsh_next;
            txd_reg <= txd_next;
        end
    end

    assign txd = txd_reg;
    assign rx_valid = rv_reg;
    assign rx_data = rsh_reg;
    assign tx_busy = (ts_reg != HVRCS_U_IDLE);

    // line idles high between characters
    a_tx_idle_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ts_reg == HVRCS_U_IDLE) |-> txd) else $error("serial line low while idle");
endmodule

// >>> logic/hvrcs_supervisor.sv
`timescale 1ns/1ps
`include "hvrcs_cfg.svh"
// Notes on behaviour
// - clamp setpoints to software limits
// - voltage over limit sets status and event
// - current over limit sets status and event
// - kill mode: limit event drops output instantly
// - shutdown events latch until button or clear
// - emergency, trip, kill-mode limits are shutdowns
// - loop and temperature events stay set until button or clear
// - only the selected interface commands
// - first command enters remote, lights led
// - local button hands control to panel
// - new command in local returns remote
// - on/off in remote drops output, local
// - serial 9600 baud, 8N1
// - echo each received character while serial is selected
// - commands end with CR then LF
// - bus EOI on last byte ends command
// - bus address 1 to 30, default 17
// - numbers passed verbatim, no zero padding
// - tcp server on port 10001
// - one query and answer per connection
module hvrcs_supervisor #(
    parameter int W = 16,
    parameter int BIT_CYC = `HVRCS_BIT_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // setpoints, limits and nominals
    input wire logic [W-1:0] volt_setpoint_req,
    input wire logic [W-1:0] curr_setpoint_req,
    input wire logic [W-1:0] volt_soft_limit,
    input wire logic [W-1:0] curr_soft_limit,
    input wire logic [W-1:0] nominal_voltage,
    input wire logic [W-1:0] nominal_current,
    // measurements
    input wire logic meas_valid,
    input wire logic [W-1:0] meas_volt,
    input wire logic [W-1:0] meas_curr,
    // modes and panel pins
    input wire logic kill_enable,
    input wire hvrcs_pkg::hvrcs_iface_t interface_select_setting,
    input wire logic local_button,
    input wire logic onoff_button,
    input wire logic kill_escape_button,
    input wire logic safety_loop_open,
    input wire logic overtemp,
    // requests from the command executor
    input wire logic remote_output_on_state,
    input wire logic remote_hv_off,
    input wire logic gpib_addr_wr,
    input wire logic [4:0] gpib_addr_val,
    // serial pins
    input wire logic serial_rxd,
    output logic serial_txd,
    // bus and tcp character streams
    input wire logic gpib_valid,
    input wire logic [7:0] gpib_data,
    input wire logic gpib_eoi,
    input wire logic eth_valid,
    input wire logic [7:0] eth_data,
    // answer characters to the serial host
    input wire logic ans_valid,
    input wire logic [7:0] ans_data,
    output logic ans_ready,
    // command stream to the executor
    output logic cmd_valid,
    output logic [7:0] cmd_data,
    output logic cmd_end,
    // applied setpoints and status
    output logic [W-1:0] volt_setpoint,
    output logic [W-1:0] curr_setpoint,
    output logic volt_limit_status,
    output logic curr_limit_status,
    output logic volt_limit_event,
    output logic curr_limit_event,
    output logic emergency_off_event,
    output logic current_trip_event,
    output logic safety_loop_event,
    output logic overtemp_event,
    output logic output_on_state,
    output logic remote_led,
    output logic [4:0] gpib_address,
    output logic [15:0] tcp_port
);
    import hvrcs_pkg::*;
    logic rst_meta_reg, rst_sync_n;
    logic [4:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic [4:0] pins, edges;
    logic rx_valid, tx_busy;
    logic [7:0] rx_data;
    logic [W:0] thr_v, thr_c;
    logic byte_v, byte_eoi, term_now, clr_now, emcy_now;
    logic [7:0] byte_d;
    logic over_v, over_c, trip_now, blocked;
    hvrcs_ctrl_t ctrl_reg, ctrl_next;
    logic [W-1:0] volt_setpoint_reg, volt_setpoint_next, iset_reg, iset_next;
    logic vst_reg, vst_next, cst_reg, cst_next;
    logic [5:0] ev_reg, ev_next; // vlim clim emcy trip sfl temp
    logic on_reg, on_next, led_reg, led_next;
    logic cr_reg, cr_next, cv_reg, cv_next, ce_reg, ce_next;
    logic [7:0] cd_reg, cd_next;
    logic [31:0] win_reg, win_next;
    logic [4:0] addr_reg, addr_next;
    logic ep_reg, ep_next, ah_reg, ah_next, ar_reg, ar_next, ts_reg, ts_next;
    logic [7:0] eb_reg, eb_next, ab_reg, ab_next, td_reg, td_next;

    // compares the last four command characters with a code
    function automatic logic cmd_is(input logic [31:0] win, input logic [31:0] code);
        cmd_is = (win == code);
    endfunction

    // reset released through two flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    // panel pins: two-flop sync, third flop only for edges
    assign pins = {overtemp, safety_loop_open, kill_escape_button, onoff_button, local_button};
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
            pin_prev_reg <= 5'h00;
        end
        else
        begin
            pin_meta_reg <= pins;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end
    assign edges = pin_sync_reg & ~pin_prev_reg;

    hvrcs_uart #(.BIT_CYC(BIT_CYC)) u_uart (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .rxd(serial_rxd),
        .txd(serial_txd),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .tx_start(ts_reg),
        .tx_data(td_reg),
        .tx_busy(tx_busy)
    );

    // thresholds are limit plus nominal / 50, one bit wider to avoid wrap
    assign thr_v = {1'b0, volt_soft_limit} + {1'b0, nominal_voltage / W'(`HVRCS_MARGIN_DIV)};
    assign thr_c = {1'b0, curr_soft_limit} + {1'b0, nominal_current / W'(`HVRCS_MARGIN_DIV)};
    assign over_v = meas_valid && ({1'b0, meas_volt} >= thr_v);
    assign over_c = meas_valid && ({1'b0, meas_curr} >= thr_c);
    assign trip_now = kill_enable && meas_valid && (meas_curr >= iset_reg);

    // only the selected interface feeds the command stream
    always_comb
    begin
        byte_v = 1'b0;
        byte_d = 8'h00;
        byte_eoi = 1'b0;
        case (interface_select_setting)
            HVRCS_IF_SERIAL:
            begin
                byte_v = rx_valid;
                byte_d = rx_data;
            end
            HVRCS_IF_GPIB:
            begin
                byte_v = gpib_valid;
                byte_d = gpib_data;
                byte_eoi = gpib_eoi;
            end
            HVRCS_IF_ETH:
            begin
                byte_v = eth_valid;
                byte_d = eth_data;
            end
            default:
                byte_v = 1'b0;
        endcase
    end
    // CR LF or bus EOI closes the command
    assign term_now = byte_v && (byte_eoi || (cr_reg && byte_d == `HVRCS_CHR_LF));
    assign clr_now = (term_now && cmd_is(byte_eoi ? {win_reg[23:0], byte_d} : win_reg,
        `HVRCS_CMD_CLEAR)) || edges[2];
    assign emcy_now = term_now && cmd_is(byte_eoi ? {win_reg[23:0], byte_d} : win_reg,
        `HVRCS_CMD_EMCY);
    // latched shutdowns; limit events only shut down in kill mode
    assign blocked = |ev_reg[5:2] || (kill_enable && |ev_reg[1:0]);

    // supervisor next state
    always_comb
    begin
        ctrl_next = ctrl_reg;
        volt_setpoint_next = (volt_setpoint_req > volt_soft_limit) ? volt_soft_limit : volt_setpoint_req;
        iset_next = (curr_setpoint_req > curr_soft_limit) ? curr_soft_limit : curr_setpoint_req;
        vst_next = meas_valid ? over_v : vst_reg;
        cst_next = meas_valid ? over_c : cst_reg;
        // clear first so that a new event in the same cycle wins
        ev_next = clr_now ? 6'h00 : ev_reg;
        ev_next = ev_next | {pin_sync_reg[4], pin_sync_reg[3], trip_now, emcy_now, over_c, over_v};
        on_next = on_reg;
        if (remote_hv_off && ctrl_reg == HVRCS_REMOTE)
            on_next = 1'b0;
        if (remote_output_on_state && ctrl_reg == HVRCS_REMOTE)
            on_next = 1'b1;
        if (edges[1])
        begin
            if (ctrl_reg == HVRCS_REMOTE && on_reg)
            begin
                on_next = 1'b0;
                ctrl_next = HVRCS_LOCAL;
            end
            else if (ctrl_reg == HVRCS_LOCAL)
                on_next = !on_reg;
        end
        if (edges[0])
            ctrl_next = HVRCS_LOCAL;
        if (term_now)
            ctrl_next = HVRCS_REMOTE;
        // latched event forbids the output, no ramp
        if (blocked || (kill_enable && (over_v || over_c)) || emcy_now || trip_now
            || pin_sync_reg[4] || pin_sync_reg[3])
            on_next = 1'b0;
        led_next = (ctrl_reg == HVRCS_REMOTE);
        // command characters pass verbatim, numbers are not reformatted
        cv_next = byte_v;
        cd_next = byte_d;
        ce_next = term_now;
        cr_next = byte_v ? (byte_d == `HVRCS_CHR_CR) : cr_reg;
        win_next = win_reg;
        if (term_now)
            win_next = 32'h00000000;
        else if (byte_v && byte_d != `HVRCS_CHR_CR && byte_d != `HVRCS_CHR_LF)
            win_next = {win_reg[23:0], byte_d};
        addr_next = addr_reg;
        if (gpib_addr_wr && gpib_addr_val >= `HVRCS_GPIB_ADDR_MIN
            && gpib_addr_val <= `HVRCS_GPIB_ADDR_MAX)
            addr_next = gpib_addr_val;
        // serial output: echo beats answers, host paces on echoes
        ep_next = ep_reg;
        eb_next = eb_reg;
        if (rx_valid && interface_select_setting == HVRCS_IF_SERIAL)
        begin
            ep_next = 1'b1;
            eb_next = rx_data;
        end
        ah_next = ah_reg;
        ab_next = ab_reg;
        if (ans_valid && ar_reg)
        begin
            ah_next = 1'b1;
            ab_next = ans_data;
        end
        ts_next = 1'b0;
        td_next = td_reg;
        if (!ts_reg && !tx_busy)
        begin
            if (ep_reg)
            begin
                ts_next = 1'b1;
                td_next = eb_reg;
                ep_next = (rx_valid && interface_select_setting == HVRCS_IF_SERIAL);
            end
            else if (ah_reg)
            begin
                ts_next = 1'b1;
                td_next = ab_reg;
                ah_next = 1'b0;
            end
        end
        ar_next = !ah_next && !(ans_valid && ar_reg)
            && interface_select_setting == HVRCS_IF_SERIAL;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ctrl_reg <= HVRCS_LOCAL;
            volt_setpoint_reg <= '0;
            iset_reg <= '0;
            vst_reg <= 1'b0;
            cst_reg <= 1'b0;
            ev_reg <= 6'h00;
            on_reg <= 1'b0;
            led_reg <= 1'b0;
            cv_reg <= 1'b0;
            cd_reg <= 8'h00;
            ce_reg <= 1'b0;
            cr_reg <= 1'b0;
            win_reg <= 32'h00000000;
            addr_reg <= `HVRCS_GPIB_ADDR_RST;
            ep_reg <= 1'b0;
            eb_reg <= 8'h00;
            ah_reg <= 1'b0;
            ab_reg <= 8'h00;
            ar_reg <= 1'b0;
            ts_reg <= 1'b0;
            td_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            volt_setpoint_reg <= volt_setpoint_next;
            iset_reg <= iset_next;
            vst_reg <= vst_next;
            cst_reg <= cst_next;
            ev_reg <= ev_next;
            on_reg <= on_next;
            led_reg <= led_next;
            cv_reg <= cv_next;
            cd_reg <= cd_next;
            ce_reg <= ce_next;
            cr_reg <= cr_next;
            win_reg <= win_next;
            addr_reg <= addr_next;
            ep_reg <= ep_next;
            eb_reg <= eb_next;
            ah_reg <= ah_next;
            ab_reg <= ab_next;
            ar_reg <= ar_next;
            ts_reg <= ts_next;
            td_reg <= td_next;
        end
    end

    assign volt_setpoint = volt_setpoint_reg;
    assign curr_setpoint = iset_reg;
    assign volt_limit_status = vst_reg;
    assign curr_limit_status = cst_reg;
    assign {overtemp_event, safety_loop_event, current_trip_event} = ev_reg[5:3];
    assign {emergency_off_event, curr_limit_event, volt_limit_event} = ev_reg[2:0];
    assign output_on_state = on_reg;
    assign remote_led = led_reg;
    assign cmd_valid = cv_reg;
    assign cmd_data = cd_reg;
    assign cmd_end = ce_reg;
    assign gpib_address = addr_reg;
    assign ans_ready = ar_reg;
    // constant, but held in a flop like every other output
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            tcp_port <= `HVRCS_TCP_PORT;
        else
            tcp_port <= `HVRCS_TCP_PORT;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);
    sequence s_cmd_done;
        term_now && !edges[0];
    endsequence
    sequence s_remote_lit;
        (ctrl_reg == HVRCS_REMOTE) ##1 remote_led;
    endsequence
    a_volt_clamp: assert property ($past(rst_sync_n) |-> volt_setpoint <= $past(volt_soft_limit))
        else $error("voltage setpoint above limit");
    a_vlim_sets: assert property (over_v |=> volt_limit_event && volt_limit_status)
        else $error("voltage limit bits not set");
    a_clim_sets: assert property (over_c |=> curr_limit_event && curr_limit_status)
        else $error("current limit bits not set");
    a_kill_drops: assert property (kill_enable && (volt_limit_event || curr_limit_event)
        |=> !output_on_state)
        else $error("output on with kill-mode limit event");
    a_event_holds: assert property (emergency_off_event && !clr_now |=> emergency_off_event)
        else $error("shutdown event lost without clear");
    a_trip_latch: assert property (trip_now |=> current_trip_event && !output_on_state)
        else $error("current trip not latched");
    a_loop_sticky: assert property (safety_loop_event && !clr_now |=> safety_loop_event)
        else $error("safety loop event dropped");
    a_iface_only: assert property (cmd_valid |-> $past(byte_v))
        else $error("command byte from unselected interface");
    a_remote_enter: assert property (s_cmd_done |=> s_remote_lit)
        else $error("command did not enter remote");
    a_local_btn: assert property (edges[0] && !term_now |=> ##1 !remote_led)
        else $error("local button did not release remote");
    a_onoff_local: assert property (edges[1] && ctrl_reg == HVRCS_REMOTE && on_reg && !term_now
        |=> !output_on_state && ctrl_reg == HVRCS_LOCAL)
        else $error("on/off in remote did not go local");
    a_echo_queue: assert property (rx_valid && interface_select_setting == HVRCS_IF_SERIAL
        |=> ep_reg || ts_reg)
        else $error("received character not echoed");
    a_addr_range: assert property (gpib_address >= `HVRCS_GPIB_ADDR_MIN
        && gpib_address <= `HVRCS_GPIB_ADDR_MAX)
        else $error("bus address out of range");
endmodule

// >>> verification/hvrcs_host.sv
`timescale 1ns/1ps
module hvrcs_host #(
    parameter int BIT_CYC = 8
) (
    // host side serial pins
    input wire logic ref_clk,
    output logic rxd,
    input wire logic txd,
    // last character heard
    output logic [7:0] rx_char,
    output logic rx_seen
);
    initial rxd = 1'b1;
    initial rx_seen = 1'b0;
    // 8N1 frame, lsb first; line idles high between frames
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd <= f[i];
            repeat (BIT_CYC) @(posedge ref_clk);
        end
    endtask
    // receiver samples mid-bit, free running output needs no reply
    always
    begin
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(posedge ref_clk);
            rx_char[i] = txd;
        end
        repeat (BIT_CYC) @(posedge ref_clk);
        rx_seen = ~rx_seen;
    end
endmodule

// >>> verification/hvrcs_supervisor_tb.sv
`timescale 1ns/1ps
module hvrcs_supervisor_tb;
    import hvrcs_pkg::*;
    // design inputs
    logic ref_clk = 0, rst_n = 0, meas_valid = 0, kill_enable = 0, overtemp = 0, zero = 0;
    logic gpib_valid = 0, gpib_eoi = 0, eth_valid = 0, gpib_addr_wr = 0, serial_rxd;
    logic [2:0] btn = 0;
    logic [4:0] gpib_addr_val = 0;
    logic [7:0] gpib_data = 0, eth_data = 0, ans_data = 0, echo;
    logic [15:0] volt_setpoint_req = 0, curr_setpoint_req = 0, volt_soft_limit = 0;
    logic [15:0] curr_soft_limit = 0, nominal_voltage = 0, meas_volt = 0, meas_curr = 0;
    hvrcs_iface_t interface_select_setting = HVRCS_IF_GPIB;
    // design outputs
    logic serial_txd, cmd_end, volt_limit_status, volt_limit_event, output_on_state;
    logic remote_led, overtemp_event, seen;
    logic [4:0] gpib_address;
    logic [15:0] volt_setpoint, curr_setpoint, tport;
    int err_total = 0, n_checks = 0, n_end = 0;
    hvrcs_supervisor #(.BIT_CYC(8)) i_hvrcs_supervisor (.ref_clk, .rst_n, .volt_setpoint_req,
        .curr_setpoint_req, .volt_soft_limit, .curr_soft_limit, .nominal_voltage,
        .nominal_current(nominal_voltage), .meas_valid, .meas_volt, .meas_curr, .kill_enable,
        .interface_select_setting, .local_button(btn[0]), .onoff_button(btn[1]),
        .kill_escape_button(btn[2]), .safety_loop_open(zero), .overtemp, .remote_output_on_state(zero),
        .remote_hv_off(zero), .gpib_addr_wr, .gpib_addr_val, .serial_rxd, .serial_txd,
        .gpib_valid, .gpib_data, .gpib_eoi, .eth_valid, .eth_data, .ans_valid(zero), .ans_data,
        .ans_ready(), .cmd_valid(), .cmd_data(), .cmd_end, .volt_setpoint, .curr_setpoint,
        .volt_limit_status, .curr_limit_status(), .volt_limit_event, .curr_limit_event(),
        .emergency_off_event(), .current_trip_event(), .safety_loop_event(), .overtemp_event,
        .output_on_state, .remote_led, .gpib_address, .tcp_port(tport));
    hvrcs_host #(.BIT_CYC(8)) i_hvrcs_host (.ref_clk, .rxd(serial_rxd), .txd(serial_txd),
        .rx_char(echo), .rx_seen(seen));
    // clock, end-of-command count, watchdog
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) n_end += (cmd_end === 1'b1);
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        final_report();
    end
    function automatic logic [15:0] clamp(logic [15:0] r, logic [15:0] l);
        return (r > l) ? l : r;
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    // one bus byte, then three idle cycles before the next
    task automatic gb(logic [7:0] c, logic e);
        gpib_data <= c;
        gpib_eoi <= e;
        gpib_valid <= 1;
        tick(1);
        gpib_valid <= 0;
        tick(3);
    endtask
    task automatic push(logic [2:0] b);
        btn <= b;
        tick(6);
        btn <= 0;
        tick(6);
    endtask
    task automatic meas(logic [15:0] v);
        meas_volt <= v;
        meas_valid <= 1;
        tick(1);
        meas_valid <= 0;
        tick(2);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        void'($urandom(32'ha3153fee));
        tick(8);
        rst_n <= 1;
        tick(5);
        chk("addr", 16'h0011, gpib_address);
        chk("port", 16'h2711, tport);
        gpib_addr_val <= 5'h1F;
        gpib_addr_wr <= 1;
        tick(1);
        gpib_addr_wr <= 0;
        tick(2);
        chk("addr", 16'h0011, gpib_address);
        for (int i = 0; i < 6; i++)
        begin
            volt_setpoint_req <= (i == 0) ? 16'h0100 : 16'($urandom);
            volt_soft_limit <= (i == 0) ? 16'h0100 : 16'($urandom);
            curr_setpoint_req <= 16'($urandom);
            curr_soft_limit <= 16'($urandom);
            tick(3);
            chk("volt_setpoint", clamp(volt_setpoint_req, volt_soft_limit), volt_setpoint);
            chk("iset", clamp(curr_setpoint_req, curr_soft_limit), curr_setpoint);
        end
        nominal_voltage <= 16'h0FA0;
        volt_soft_limit <= 16'h0100;
        curr_soft_limit <= 16'hFFFF;
        kill_enable <= 1;
        push(3'b010);
        chk("on", 1, output_on_state);
        meas(16'h014F);
        chk("vstat", 0, volt_limit_status);
        meas(16'h0150);
        chk("vstat", 1, volt_limit_status);
        chk("on", 0, output_on_state);
        push(3'b010);
        chk("on", 0, output_on_state);
        meas(16'h0000);
        chk("vevt", 1, volt_limit_event);
        push(3'b100);
        chk("vevt", 0, volt_limit_event);
        push(3'b010);
        eth_valid <= 1;
        tick(1);
        eth_valid <= 0;
        tick(4);
        chk("led", 0, remote_led);
        gb(8'h53, 0);
        gb(8'h0D, 0);
        gb(8'h0A, 0);
        chk("end", 1, 16'(n_end));
        chk("led", 1, remote_led);
        push(3'b010);
        chk("on", 0, output_on_state);
        chk("led", 0, remote_led);
        gb(8'h58, 1);
        chk("end", 2, 16'(n_end));
        chk("led", 1, remote_led);
        push(3'b001);
        chk("led", 0, remote_led);
        overtemp <= 1;
        tick(6);
        overtemp <= 0;
        tick(6);
        chk("temp", 1, overtemp_event);
        interface_select_setting <= HVRCS_IF_SERIAL;
        gpib_data <= 8'($urandom);
        tick(1);
        i_hvrcs_host.send(gpib_data);
        for (int i = 0; i < 200 && seen !== 1'b1; i++)
            tick(1);
        chk("echo", gpib_data, echo);
        i_hvrcs_host.send(8'h0D);
        i_hvrcs_host.send(8'h0A);
        tick(4);
        chk("led", 1, remote_led);
        final_report();
    end
endmodule
